// >>> clock_select_pkg.sv
package clock_select_pkg;

	// Register byte offsets
	localparam logic [11:0] SYSTEM_CONTROL_OFFSET = 12'h000;
	localparam logic [11:0] LOOP_CONTROL_OFFSET = 12'h004;
	localparam logic [11:0] STATUS_OFFSET = 12'h008;

	// Clock source selector encodings
	localparam logic [1:0] SEL_WAKEUP = 2'h0;
	localparam logic [1:0] SEL_RESERVED = 2'h1;
	localparam logic [1:0] SEL_LOOP = 2'h2;
	localparam logic [1:0] SEL_DIRECT = 2'h3;

	// Internal routes of the output multiplexer
	localparam logic [1:0] ROUTE_WAKEUP = 2'h0;
	localparam logic [1:0] ROUTE_PRESCALE = 2'h1;
	localparam logic [1:0] ROUTE_LOOP = 2'h2;
	localparam logic [1:0] ROUTE_DIRECT = 2'h3;

	// Synchronised pin indices
	localparam int unsigned PIN_EXTERNAL = 0;
	localparam int unsigned PIN_CRYSTAL = 1;
	localparam int unsigned PIN_INTERNAL = 2;
	localparam int unsigned PIN_WAKEUP = 3;
	localparam int unsigned PIN_COUNT = 4;

	// Field widths
	localparam int unsigned PRESCALE_W = 10;
	localparam int unsigned REF_DIV_W = 4;
	localparam int unsigned FEEDBACK_W = 7;
	localparam int unsigned OUT_DIV_W = 7;

	// VCO band limits as least half-period in system cycles (clk 250 MHz)
	localparam int unsigned CLK_MHZ = 250;
	localparam int unsigned BAND0_MAX_MHZ = 110;
	localparam int unsigned BAND1_MAX_MHZ = 160;
	localparam int unsigned BAND0_MIN_HALF = (CLK_MHZ + 2 * BAND0_MAX_MHZ - 1) / (2 * BAND0_MAX_MHZ);
	localparam int unsigned BAND1_MIN_HALF = (CLK_MHZ + 2 * BAND1_MAX_MHZ - 1) / (2 * BAND1_MAX_MHZ);

	typedef struct packed {
		logic [25:0] unused;
		logic [1:0] vco_band_field;
		logic reference_select;
		logic vco_bypass_bit;
		logic [1:0] clock_source_selector;
	} system_control_word_t;

	typedef struct packed {
		logic pad3;
		logic [OUT_DIV_W-1:0] loop_output_divider_field;
		logic pad2;
		logic [FEEDBACK_W-1:0] feedback_multiplier_field;
		logic [REF_DIV_W-1:0] reference_divider_field;
		logic [1:0] pad1;
		logic [PRESCALE_W-1:0] prescale_divider_field;
	} loop_control_word_t;

	localparam system_control_word_t SYSTEM_CONTROL_RESET = '{
		unused: 26'h000_0000,
		vco_band_field: 2'h0,
		reference_select: 1'b0,
		vco_bypass_bit: 1'b1,
		clock_source_selector: SEL_WAKEUP
	};

	localparam loop_control_word_t LOOP_CONTROL_RESET = '{
		pad3: 1'b0,
		loop_output_divider_field: 7'h01,
		pad2: 1'b0,
		feedback_multiplier_field: 7'h03,
		reference_divider_field: 4'h0,
		pad1: 2'h0,
		prescale_divider_field: 10'h000
	};

	localparam int unsigned STATUS_ROUTE_LSB = 0;
	localparam int unsigned STATUS_SWITCHING_BIT = 2;
	localparam int unsigned STATUS_LOCK_BIT = 3;
	localparam int unsigned STATUS_PERIOD_LSB = 16;

endpackage

// >>> system_clock_source_select.sv
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps

module system_clock_source_select #(
	parameter int unsigned MEAS_W = 16,
	parameter int unsigned SLEW_SHIFT = 3
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic external_clock_pin_i,
	input wire logic crystal_input_pin_i,
	input wire logic internal_clock_i,
	input wire logic wakeup_clock_i,
	output logic sys_clk_o,
	output logic [1:0] source_active_o,
	output logic loop_locked_o
);

	typedef enum logic {ST_RUN, ST_HOLD} switch_state_t;

	clock_select_pkg::system_control_word_t ctrl_q;
	clock_select_pkg::loop_control_word_t div_q;
	switch_state_t state_q;

	logic [clock_select_pkg::PIN_COUNT-1:0] pins_raw;
	logic [clock_select_pkg::PIN_COUNT-1:0] pins_s1_q;
	logic [clock_select_pkg::PIN_COUNT-1:0] pins_q;

	assign pins_raw = {wakeup_clock_i, internal_clock_i, crystal_input_pin_i,
		external_clock_pin_i};

	// Every source is asynchronous to clk_i, so each passes two flops first
	genvar gi;
	generate
		for (gi = 0; gi < clock_select_pkg::PIN_COUNT; gi++) begin : g_sync
			always_ff @(posedge clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					pins_s1_q[gi] <= 1'b0;
					pins_q[gi] <= 1'b0;
				end else begin
					pins_s1_q[gi] <= pins_raw[gi];
					pins_q[gi] <= pins_s1_q[gi];
				end
			end
		end
	endgenerate

	// ---------------- APB slave ----------------
	logic setup_phase;
	logic access_done;
	logic addr_ok;
	logic [31:0] status_word;
	logic [31:0] read_mux;
	logic loop_locked_q;
	logic [MEAS_W-1:0] period_q;
	logic [1:0] cur_route_q;

	assign setup_phase = psel_i && !penable_i;
	assign access_done = psel_i && penable_i && pready_o;
	assign addr_ok = (paddr_i == clock_select_pkg::SYSTEM_CONTROL_OFFSET) ||
		(paddr_i == clock_select_pkg::LOOP_CONTROL_OFFSET) ||
		(paddr_i == clock_select_pkg::STATUS_OFFSET && !pwrite_i);

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[clock_select_pkg::STATUS_ROUTE_LSB +: 2] = cur_route_q;
		status_word[clock_select_pkg::STATUS_SWITCHING_BIT] = (state_q == ST_HOLD);
		status_word[clock_select_pkg::STATUS_LOCK_BIT] = loop_locked_q;
		status_word[clock_select_pkg::STATUS_PERIOD_LSB +: MEAS_W] = period_q;
	end

	always_comb begin
		case (paddr_i)
			clock_select_pkg::SYSTEM_CONTROL_OFFSET: read_mux = {26'h000_0000, ctrl_q[5:0]};
			clock_select_pkg::LOOP_CONTROL_OFFSET: read_mux = div_q;
			clock_select_pkg::STATUS_OFFSET: read_mux = status_word;
			default: read_mux = 32'h0000_0000;
		endcase
	end

	// Answer is prepared in the setup cycle, so every access ends in one cycle
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h0000_0000;
		end else begin
			pready_o <= setup_phase;
			pslverr_o <= setup_phase && !addr_ok;
			prdata_o <= (setup_phase && !pwrite_i) ? read_mux : 32'h0000_0000;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_q <= clock_select_pkg::SYSTEM_CONTROL_RESET;
		end else if (access_done && pwrite_i &&
				paddr_i == clock_select_pkg::SYSTEM_CONTROL_OFFSET) begin
			ctrl_q.vco_band_field <= pwdata_i[5:4];
			ctrl_q.reference_select <= pwdata_i[3];
			ctrl_q.vco_bypass_bit <= pwdata_i[2];
			// Reserved code is dropped, the running source stays selected
			if (pwdata_i[1:0] != clock_select_pkg::SEL_RESERVED) begin
				ctrl_q.clock_source_selector <= pwdata_i[1:0];
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			div_q <= clock_select_pkg::LOOP_CONTROL_RESET;
		end else if (access_done && pwrite_i &&
				paddr_i == clock_select_pkg::LOOP_CONTROL_OFFSET) begin
			div_q <= pwdata_i & 32'h7F7F_F3FF;
		end
	end

	// ---------------- Prescaler ----------------
	logic osc_lvl;
	logic osc_prev_q;
	logic osc_edge;
	logic osc_rise;
	logic [10:0] k1;
	logic [10:0] k1_cnt_q;
	logic pre_lvl_q;

	// Reference for both prescaler and loop: crystal pin or internal source
	assign osc_lvl = ctrl_q.reference_select ? pins_q[clock_select_pkg::PIN_INTERNAL] :
		pins_q[clock_select_pkg::PIN_CRYSTAL];
	assign osc_edge = osc_lvl ^ osc_prev_q;
	assign osc_rise = osc_lvl && !osc_prev_q;
	assign k1 = {1'b0, div_q.prescale_divider_field} + 11'h001;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			osc_prev_q <= 1'b0;
		end else begin
			osc_prev_q <= osc_lvl;
		end
	end

	// Toggling every K1 edges gives K1 source periods per output period
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			k1_cnt_q <= 11'h000;
			pre_lvl_q <= 1'b0;
		end else if (k1 == 11'h001) begin
			k1_cnt_q <= 11'h000;
			pre_lvl_q <= osc_lvl;
		end else if (osc_edge) begin
			if (k1_cnt_q + 11'h001 >= k1) begin
				k1_cnt_q <= 11'h000;
				pre_lvl_q <= !pre_lvl_q;
			end else begin
				k1_cnt_q <= k1_cnt_q + 11'h001;
			end
		end
	end

	// ---------------- Loop model ----------------
	logic loop_on;
	logic [4:0] p_div;
	logic [4:0] p_cnt_q;
	logic ref_tick;
	logic [MEAS_W-1:0] meas_cnt_q;
	logic [MEAS_W-1:0] meas_q;
	logic [MEAS_W-1:0] two_n;
	logic [MEAS_W-1:0] floor_period;
	logic [MEAS_W-1:0] target;
	logic [MEAS_W-1:0] slew;
	logic [MEAS_W:0] acc_q;
	logic [MEAS_W:0] acc_sum;
	logic half_tick;
	logic [7:0] k2;
	logic [7:0] k2_cnt_q;
	logic loop_lvl_q;

	assign loop_on = (ctrl_q.clock_source_selector == clock_select_pkg::SEL_LOOP) &&
		!ctrl_q.vco_bypass_bit;
	assign p_div = {1'b0, div_q.reference_divider_field} + 5'h01;
	assign ref_tick = loop_on && osc_rise && (p_cnt_q + 5'h01 >= p_div);
	assign two_n = MEAS_W'({1'b0, div_q.feedback_multiplier_field, 1'b0} + 9'h002);
	// Band sets the least VCO half-period, i.e. its top frequency
	assign floor_period = (ctrl_q.vco_band_field == 2'h1) ?
		MEAS_W'(two_n * clock_select_pkg::BAND1_MIN_HALF) :
		MEAS_W'(two_n * clock_select_pkg::BAND0_MIN_HALF);
	assign target = (meas_q > floor_period) ? meas_q : floor_period;
	assign slew = ((period_q > target) ? (period_q - target) : (target - period_q))
		>> SLEW_SHIFT;
	assign acc_sum = acc_q + {1'b0, two_n};
	assign half_tick = loop_on && (acc_sum >= {1'b0, period_q});
	assign k2 = {1'b0, div_q.loop_output_divider_field} + 8'h01;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			p_cnt_q <= 5'h00;
			meas_cnt_q <= '0;
			meas_q <= '1;
		end else if (!loop_on) begin
			p_cnt_q <= 5'h00;
			meas_cnt_q <= '0;
			meas_q <= '1;
		end else begin
			if (osc_rise) begin
				p_cnt_q <= ref_tick ? 5'h00 : p_cnt_q + 5'h01;
			end
			if (ref_tick) begin
				// Saturate so a lost reference reads as slowest, never wraps
				meas_q <= (meas_cnt_q == '1) ? '1 : meas_cnt_q + MEAS_W'(1);
				meas_cnt_q <= '0;
			end else if (meas_cnt_q != '1) begin
				meas_cnt_q <= meas_cnt_q + MEAS_W'(1);
			end
		end
	end

	// Loop starts slow and walks toward the measured period, or the band floor when that is longer, in fractions
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			period_q <= '1;
			loop_locked_q <= 1'b0;
		end else if (!loop_on) begin
			period_q <= '1;
			loop_locked_q <= 1'b0;
		end else if (ref_tick) begin
			if (period_q > target) begin
				period_q <= period_q - slew - MEAS_W'(1);
			end else if (period_q < target) begin
				period_q <= period_q + slew + MEAS_W'(1);
			end
			// No lock before a reference period has been measured
			loop_locked_q <= (period_q == target) && (meas_q != '1);
		end
	end

	// Two half-ticks per VCO cycle at rate 2N per P reference periods
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			acc_q <= '0;
		end else if (!loop_on) begin
			acc_q <= '0;
		end else begin
			acc_q <= half_tick ? acc_sum - {1'b0, period_q} : acc_sum;
		end
	end

	// Toggle every K2 half-ticks: one output period is K2 VCO cycles
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			k2_cnt_q <= 8'h00;
			loop_lvl_q <= 1'b0;
		end else if (!loop_on) begin
			k2_cnt_q <= 8'h00;
			loop_lvl_q <= 1'b0;
		end else if (half_tick) begin
			if (k2_cnt_q + 8'h01 >= k2) begin
				k2_cnt_q <= 8'h00;
				loop_lvl_q <= !loop_lvl_q;
			end else begin
				k2_cnt_q <= k2_cnt_q + 8'h01;
			end
		end
	end

	// ---------------- Glitch-free output switch ----------------
	logic [1:0] req_route;
	logic [3:0] cand;
	logic cur_lvl;

	always_comb begin
		case (ctrl_q.clock_source_selector)
			clock_select_pkg::SEL_DIRECT: req_route = clock_select_pkg::ROUTE_DIRECT;
			clock_select_pkg::SEL_LOOP: req_route = ctrl_q.vco_bypass_bit ?
				clock_select_pkg::ROUTE_PRESCALE : clock_select_pkg::ROUTE_LOOP;
			default: req_route = clock_select_pkg::ROUTE_WAKEUP;
		endcase
	end

	assign cand[clock_select_pkg::ROUTE_WAKEUP] = pins_q[clock_select_pkg::PIN_WAKEUP];
	assign cand[clock_select_pkg::ROUTE_PRESCALE] = pre_lvl_q;
	assign cand[clock_select_pkg::ROUTE_LOOP] = loop_lvl_q;
	assign cand[clock_select_pkg::ROUTE_DIRECT] = pins_q[clock_select_pkg::PIN_EXTERNAL];
	assign cur_lvl = cand[cur_route_q];

	// Leave old source only while low, join new source only while low
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= ST_RUN;
			cur_route_q <= clock_select_pkg::ROUTE_WAKEUP;
			sys_clk_o <= 1'b0;
		end else begin
			case (state_q)
				ST_RUN: begin
					if (req_route != cur_route_q && !cur_lvl) begin
						state_q <= ST_HOLD;
						cur_route_q <= req_route;
						sys_clk_o <= 1'b0;
					end else begin
						sys_clk_o <= cur_lvl;
					end
				end
				ST_HOLD: begin
					sys_clk_o <= 1'b0;
					cur_route_q <= req_route;
					if (req_route == cur_route_q && !cur_lvl) begin
						state_q <= ST_RUN;
					end
				end
				default: begin
					state_q <= ST_RUN;
					sys_clk_o <= 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			source_active_o <= clock_select_pkg::ROUTE_WAKEUP;
			loop_locked_o <= 1'b0;
		end else begin
			source_active_o <= cur_route_q;
			loop_locked_o <= loop_locked_q;
		end
	end

endmodule

// >>> system_clock_source_select_checker.sv
`timescale 1ns/1ps
module system_clock_source_select_checker #(
	parameter int unsigned MEAS_W = 16,
	parameter int unsigned SLEW_SHIFT = 3
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic external_clock_pin_i,
	input wire logic wakeup_clock_i,
	input wire logic sys_clk_o,
	input wire logic [1:0] source_active_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	logic [1:0] band_q;
	// Shadow of the band field so the half-period floor is known here
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			band_q <= 2'h0;
		end else if (penable_i && pwrite_i && pready_o && !pslverr_o && paddr_i == 12'h000) begin
			band_q <= pwdata_i[5:4];
		end
	end
	sequence s_setup;
		psel_i && !penable_i;
	endsequence
	sequence s_rise(logic [1:0] r);
		source_active_o == r && $rose(sys_clk_o);
	endsequence
	property p_ready_after_setup;
		s_setup |=> pready_o;
	endproperty
	property p_ready_pulse;
		pready_o |=> !pready_o;
	endproperty
	property p_err_cause;
		pready_o |-> pslverr_o == !(paddr_i inside {12'h000, 12'h004} || (paddr_i == 12'h008 && !pwrite_i));
	endproperty
	property p_rdata_idle;
		!pready_o |-> prdata_o == 32'h0000_0000;
	endproperty
	property p_sel_reserved;
		pready_o && !pwrite_i && paddr_i == 12'h000 |-> prdata_o[1:0] != 2'h1;
	endproperty
	property p_direct_follow;
		s_rise(2'h3) |-> $past(external_clock_pin_i, 2) || $past(external_clock_pin_i, 3);
	endproperty
	property p_wakeup_follow;
		s_rise(2'h0) |-> $past(wakeup_clock_i, 2) || $past(wakeup_clock_i, 3);
	endproperty
	property p_switch_low;
		$changed(source_active_o) |-> !sys_clk_o;
	endproperty
	property p_band_floor;
		s_rise(2'h2) ##0 band_q == 2'h0 |=> sys_clk_o;
	endproperty
	a_ready_after_setup: assert property (p_ready_after_setup) else $error("no pready after setup");
	a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
	a_err_cause: assert property (p_err_cause) else $error("pslverr wrong for address");
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero when idle");
	a_sel_reserved: assert property (p_sel_reserved) else $error("reserved selector read back");
	a_direct_follow: assert property (p_direct_follow) else $error("direct rise without pin");
	a_wakeup_follow: assert property (p_wakeup_follow) else $error("wakeup rise without pin");
	a_switch_low: assert property (p_switch_low) else $error("route changed while high");
	a_band_floor: assert property (p_band_floor) else $error("loop high phase too short");
endmodule

bind system_clock_source_select system_clock_source_select_checker #(.MEAS_W(MEAS_W),
	.SLEW_SHIFT(SLEW_SHIFT)) u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
	.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
	.external_clock_pin_i(external_clock_pin_i), .wakeup_clock_i(wakeup_clock_i),
	.sys_clk_o(sys_clk_o), .source_active_o(source_active_o));

// >>> testbench.sv
`timescale 1ns/1ps
module testbench;
	logic clk_i, rst_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, sys_clk_o, lock, er;
	logic [11:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, rd;
	logic [1:0] route;
	logic [3:0] pin;
	int half[4], cnt[4], bad_count, checks_done, per, hi;
	system_clock_source_select DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.external_clock_pin_i(pin[0]), .crystal_input_pin_i(pin[1]), .internal_clock_i(pin[2]),
		.wakeup_clock_i(pin[3]), .sys_clk_o(sys_clk_o), .source_active_o(route),
		.loop_locked_o(lock));
	initial begin
		clk_i = 0;
		forever #2 clk_i = ~clk_i;
	end
	// Source clocks are whole multiples of clk so expected periods are exact
	always @(posedge clk_i) begin
		for (int i = 0; i < 4; i++) begin
			cnt[i] <= (cnt[i] >= half[i] - 1) ? 0 : cnt[i] + 1;
			if (cnt[i] >= half[i] - 1) pin[i] <= ~pin[i];
		end
	end
	task check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel_i <= 1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1;
		// Request stands until pready is seen high at a rising edge
		do @(posedge clk_i); while (pready_o !== 1);
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 0;
		penable_i <= 0;
	endtask
	// First periods after a change may be partial, so skip three
	task meas;
		repeat (3) begin
			do @(negedge clk_i); while (sys_clk_o !== 0);
			do @(negedge clk_i); while (sys_clk_o !== 1);
		end
		hi = 0;
		while (sys_clk_o === 1) begin
			@(negedge clk_i);
			hi++;
		end
		per = hi;
		while (sys_clk_o === 0) begin
			@(negedge clk_i);
			per++;
		end
	endtask
	task mode(input logic [31:0] cfg, input logic [1:0] r, input int ep, input int eh);
		apb(1, 12'h000, cfg);
		for (int i = 0; i < 300 && route !== r; i++) @(negedge clk_i);
		check(32'(route), 32'(r));
		meas;
		check(32'(per), 32'(ep));
		check(32'(hi), 32'(eh));
	endtask
	task wait_lock;
		for (int i = 0; i < 20000 && lock !== 1; i++) @(negedge clk_i);
		check(32'(lock), 32'h0000_0001);
	endtask
	task t_reset;
		apb(0, 12'h000, 0);
		check(rd, 32'h0000_0004);
		apb(0, 12'h004, 0);
		check(rd, 32'h0103_0000);
		apb(0, 12'h00C, 0);
		check(32'(er), 32'h0000_0001);
		apb(1, 12'h008, 0);
		check(32'(er), 32'h0000_0001);
		$display("test reset done");
	endtask
	task t_sources;
		mode(32'h0000_0004, 2'h0, 40, 20);
		mode(32'h0000_0007, 2'h3, 6, 3);
		apb(1, 12'h000, 32'h0000_0005);
		apb(0, 12'h000, 0);
		check(rd, 32'h0000_0007);
		check(32'(route), 32'h0000_0003);
		$display("test sources done");
	endtask
	task t_prescale;
		apb(1, 12'h004, 32'h0103_0001);
		mode(32'h0000_0006, 2'h1, 32, 16);
		apb(1, 12'h004, 32'h0103_03FF);
		mode(32'h0000_000E, 2'h1, 2048, 1024);
		apb(1, 12'h004, 32'h0103_0000);
		mode(32'h0000_0006, 2'h1, 16, 8);
		$display("test prescale done");
	endtask
	task t_loop;
		apb(1, 12'h000, 32'h0000_0002);
		wait_lock;
		mode(32'h0000_0002, 2'h2, 8, 4);
		apb(0, 12'h008, 0);
		check(rd, 32'h0010_000A);
		apb(1, 12'h004, 32'h010F_0000);
		apb(1, 12'h000, 32'h0000_0012);
		// Lock falls only after the next reference measurement
		repeat (64) @(negedge clk_i);
		wait_lock;
		// Band 01 holds the VCO half-period to at least one clk, so K2=2 gives four
		mode(32'h0000_0012, 2'h2, 4, 2);
		apb(0, 12'h008, 0);
		check(rd, 32'h0020_000A);
		$display("test loop done");
	endtask
	initial begin
		{psel_i, penable_i, pwrite_i, rst_n_i, pin} = '0;
		paddr_i = 12'h000;
		pwdata_i = 32'h0000_0000;
		half = '{3, 8, 1, 20};
		cnt = '{default: 0};
		repeat (5) @(posedge clk_i);
		rst_n_i <= 1;
		t_reset;
		t_sources;
		t_prescale;
		t_loop;
		final_report;
	end
	initial begin
		#360_000;
		bad_count++;
		$display("[FAIL] %0t watchdog expired", $time);
		final_report;
	end
endmodule
